// File: rtl/sctl_regs.vh
// register offsets, field layout, reset values and timing constants of the system control block
`ifndef SCTL_REGS_VH
`define SCTL_REGS_VH

// ==========================================
// register byte offsets
`define SCTL_OFF_SYSTEM_CONTROL 12'h180
`define SCTL_OFF_IRQSTAT 12'h188
`define SCTL_OFF_IRQMASK 12'h18c
`define SCTL_OFF_DETCTRL 12'h190

// ==========================================
// system control field layout
`define SCTL_SLEEP_BIT 0
`define SCTL_CKDIV_BIT 1
`define SCTL_RSV_F 4:2
`define SCTL_SEL_F 7:5
`define SCTL_LOW_F 8:0
`define SCTL_RO_F 15:9
`define SCTL_COPY_F 24:16
`define SCTL_SIGN_BIT 17
`define SCTL_CAUGHT_BIT 18
`define SCTL_ERR_BIT 20

// ==========================================
// reset values
`define SCTL_RSV_RST 3'h1
`define SCTL_SEL_RST 3'h0
`define SCTL_COPY_RST 9'h000
`define SCTL_ERR_RST 1'h1
`define SCTL_DET_RST 5'h00

// ==========================================
// input select codes
`define SCTL_SEL_CURRENT 3'h0
`define SCTL_SEL_TEMP 3'h4

// ==========================================
// interrupt bits and detect control fields
`define SCTL_IRQ_CAUGHT 0
`define SCTL_IRQ_ERR 1
`define SCTL_IRQ_W 2
`define SCTL_DET_EN_BIT 0
`define SCTL_DET_LEN_F 4:1

// ==========================================
// bus responses
`define SCTL_RESP_OKAY 2'h0
`define SCTL_RESP_SLVERR 2'h2

// ==========================================
// clock rates in hertz
`define SCTL_MCLK_HZ 40000000
`define SCTL_FAST_HZ 3276800
`define SCTL_SLOW_HZ 819200

`endif

// File: rtl/sctl_current_detect.v
// consecutive above-threshold sample counter for current detection
`timescale 1ns/1ps
module sctl_current_detect #(
    parameter LEN_W = 4
) (
    input wire mclk,
    input wire rst,
    input wire ce,
    input wire enable,
    input wire [LEN_W-1:0] windowLen,
    input wire sampleValid,
    input wire sampleAbove,
    output reg caughtPulse,
    output reg belowNow
);
    // ==========================================
    // run counter
    reg [LEN_W:0] runCount_reg; // consecutive samples above threshold

    // count a run, pulse once when run length reaches window length plus one
    always @(posedge mclk) begin
        if (rst) begin
            runCount_reg <= {(LEN_W+1){1'b0}};
            caughtPulse <= 1'b0;
            belowNow <= 1'b1;
        end else if (ce) begin
            caughtPulse <= 1'b0;
            if (sampleValid) begin
                belowNow <= ~sampleAbove;
                if (!sampleAbove || !enable) begin
                    // run broken
                    runCount_reg <= {(LEN_W+1){1'b0}};
                end else if (runCount_reg == {1'b0, windowLen}) begin
                    // run long enough: a current is caught
                    caughtPulse <= 1'b1;
                    runCount_reg <= runCount_reg + 1'b1;
                end else if (runCount_reg <= {1'b0, windowLen}) begin
                    // still counting, saturates after the catch
                    runCount_reg <= runCount_reg + 1'b1;
                end
            end
        end
    end
endmodule // sctl_current_detect

// File: rtl/sctl_clock_gen.v
// metering and internal clock enable generator with sleep gating
`timescale 1ns/1ps
`include "sctl_regs.vh"
module sctl_clock_gen #(
    parameter CLK_HZ = `SCTL_MCLK_HZ,
    parameter FAST_HZ = `SCTL_FAST_HZ,
    parameter SLOW_HZ = `SCTL_SLOW_HZ,
    parameter CNT_W = 8
) (
    input wire mclk,
    input wire rst,
    input wire ce,
    input wire sleep,
    input wire slowSelect,
    output reg internalClockAEn,
    output reg internalClockBEn,
    output reg meteringClockTick
);
    // ==========================================
    // divider counts
    localparam integer FAST_END = CLK_HZ / FAST_HZ - 1; // last count of fast period
    localparam integer SLOW_END = CLK_HZ / SLOW_HZ - 1; // last count of slow period
    localparam [CNT_W-1:0] FAST_LAST = FAST_END[CNT_W-1:0];
    localparam [CNT_W-1:0] SLOW_LAST = SLOW_END[CNT_W-1:0];

    reg [CNT_W-1:0] divCount_reg; // cycle counter of the divider
    wire [CNT_W-1:0] divLast; // terminal count for selected rate

    // select metering rate
    assign divLast = slowSelect ? SLOW_LAST : FAST_LAST;

    // divider, held at zero while asleep so wakeup starts a fresh period
    always @(posedge mclk) begin
        if (rst) begin
            divCount_reg <= {CNT_W{1'b0}};
            meteringClockTick <= 1'b0;
            internalClockAEn <= 1'b1;
            internalClockBEn <= 1'b1;
        end else if (ce) begin
            // both internal clocks stop in sleep
            internalClockAEn <= ~sleep;
            internalClockBEn <= ~sleep;
            if (sleep) begin
                divCount_reg <= {CNT_W{1'b0}};
                meteringClockTick <= 1'b0;
            end else if (divCount_reg >= divLast) begin
                divCount_reg <= {CNT_W{1'b0}};
                meteringClockTick <= 1'b1;
            end else begin
                divCount_reg <= divCount_reg + 1'b1;
                meteringClockTick <= 1'b0;
            end
        end
    end
endmodule // sctl_clock_gen

// File: rtl/sctl_system_control.v
// system control register bank with axi4-lite slave, self-check and interrupt
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "sctl_regs.vh"
module sctl_system_control #(
    parameter ADDR_W = 12,
    parameter LEN_W = 4
) (
    input wire mclk,
    input wire rst,
    input wire ce,
    // axi4-lite write address
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // analog side
    input wire voltageSignIn,
    input wire currentSampleValid,
    input wire currentAboveThreshold,
    output reg [2:0] inputSelectA,
    output reg routeCurrent,
    output reg routeTemperature,
    output reg routeGround,
    output reg sleepMode,
    output wire internalClockAEn,
    output wire internalClockBEn,
    output wire meteringClockTick,
    output reg irq
);
    // ==========================================
    // helper functions

    // merge written bytes into an old word
    function [31:0] mergeBytes;
        input [31:0] oldWord;
        input [31:0] newWord;
        input [3:0] strb;
        integer i;
        begin
            mergeBytes = oldWord;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    mergeBytes[i*8 +: 8] = newWord[i*8 +: 8];
                end
            end
        end
    endfunction

    // word-aligned offset match
    function isAddr;
        input [ADDR_W-1:0] addr;
        input [ADDR_W-1:0] offset;
        begin
            isAddr = (addr[ADDR_W-1:2] == offset[ADDR_W-1:2]);
        end
    endfunction

    // ==========================================
    // register state
    reg sleep_reg; // sleep control
    reg clockDivSel_reg; // metering divider select
    reg [2:0] reservedLow_reg; // reserved field, no function
    reg [2:0] inputSel_reg; // measurement input select
    reg reservedB8_reg; // reserved bit 8
    reg [8:0] copy_reg; // complement copy in upper half
    reg selfcheckErr_reg; // self-check failure flag
    reg caughtFlag_reg; // current caught flag
    reg voltageSign_reg; // sampled voltage sign
    reg [`SCTL_IRQ_W-1:0] irqStatus_reg; // sticky event bits
    reg [`SCTL_IRQ_W-1:0] irqMask_reg; // interrupt enables
    reg [4:0] detCtrl_reg; // detect enable and window length

    // ==========================================
    // bus channel state
    reg awHeld_reg; // write address captured
    reg [ADDR_W-1:0] awAddr_reg; // captured write address
    reg wHeld_reg; // write data captured
    reg [31:0] wData_reg; // captured write data
    reg [3:0] wStrb_reg; // captured byte enables

    // ==========================================
    // submodule wires
    wire caughtPulse; // run long enough
    wire belowNow; // latest sample below threshold

    // ==========================================
    // readback word assembly
    wire [8:0] lowWord; // lower half as stored
    wire [31:0] sysWord; // full read value
    assign lowWord = {reservedB8_reg, inputSel_reg, reservedLow_reg,
        clockDivSel_reg, sleep_reg};
    // status bits replace their copies on read, 15..9 read zero
    assign sysWord = {7'h00, copy_reg[8:5], selfcheckErr_reg, copy_reg[3],
        caughtFlag_reg, voltageSign_reg, copy_reg[0], 7'h00, lowWord};

    // ==========================================
    // write decode
    wire doWrite; // both halves of a write present
    wire wrSys; // write hits system control
    wire wrStat; // write hits interrupt status
    wire wrMask; // write hits interrupt mask
    wire wrDet; // write hits detect control
    wire [31:0] sysMerged; // new system word after strobes
    assign doWrite = awHeld_reg & wHeld_reg & ~s_axi_bvalid;
    assign wrSys = doWrite & isAddr(awAddr_reg, `SCTL_OFF_SYSTEM_CONTROL);
    assign wrStat = doWrite & isAddr(awAddr_reg, `SCTL_OFF_IRQSTAT);
    assign wrMask = doWrite & isAddr(awAddr_reg, `SCTL_OFF_IRQMASK);
    assign wrDet = doWrite & isAddr(awAddr_reg, `SCTL_OFF_DETCTRL);
    assign sysMerged = mergeBytes(sysWord, wData_reg, wStrb_reg);

    // ==========================================
    // caught flag clear and self-check
    wire caughtClear; // software clear honoured
    wire checkFail; // new word fails self-check
    wire errRise; // self-check newly failing
    // zero written to bit 18 clears only while below threshold
    assign caughtClear = wrSys & wStrb_reg[2] & ~sysMerged[`SCTL_CAUGHT_BIT] & belowNow;
    // upper must be exact complement of lower
    assign checkFail = (sysMerged[`SCTL_COPY_F] != ~sysMerged[`SCTL_LOW_F]);
    assign errRise = wrSys & checkFail & ~selfcheckErr_reg;

    // ==========================================
    // system control register update
    always @(posedge mclk) begin
        if (rst) begin
            sleep_reg <= 1'b0;
            clockDivSel_reg <= 1'b0;
            reservedLow_reg <= `SCTL_RSV_RST;
            inputSel_reg <= `SCTL_SEL_RST;
            reservedB8_reg <= 1'b0;
            copy_reg <= `SCTL_COPY_RST;
            selfcheckErr_reg <= `SCTL_ERR_RST;
            caughtFlag_reg <= 1'b0;
            voltageSign_reg <= 1'b0;
        end else if (ce) begin
            // sign bit tracks the voltage every cycle
            voltageSign_reg <= voltageSignIn;
            if (wrSys) begin
                // reserved field stored but drives nothing
                sleep_reg <= sysMerged[`SCTL_SLEEP_BIT];
                clockDivSel_reg <= sysMerged[`SCTL_CKDIV_BIT];
                reservedLow_reg <= sysMerged[`SCTL_RSV_F];
                inputSel_reg <= sysMerged[`SCTL_SEL_F];
                reservedB8_reg <= sysMerged[8];
                // copy of complement written by software
                copy_reg <= sysMerged[`SCTL_COPY_F];
                // only an exact complement clears the flag
                selfcheckErr_reg <= checkFail;
            end
            // set wins over a clear in the same cycle
            if (caughtPulse) begin
                caughtFlag_reg <= 1'b1;
            end else if (caughtClear) begin
                caughtFlag_reg <= 1'b0;
            end
        end
    end

    // ==========================================
    // input routing decode, registered
    always @(posedge mclk) begin
        if (rst) begin
            inputSelectA <= `SCTL_SEL_RST;
            routeCurrent <= 1'b1;
            routeTemperature <= 1'b0;
            routeGround <= 1'b0;
            sleepMode <= 1'b0;
        end else if (ce) begin
            inputSelectA <= inputSel_reg;
            // reserved codes 1..3 route nothing
            routeCurrent <= (inputSel_reg == `SCTL_SEL_CURRENT);
            routeTemperature <= (inputSel_reg == `SCTL_SEL_TEMP);
            routeGround <= inputSel_reg[2] & (inputSel_reg[1] | inputSel_reg[0]);
            sleepMode <= sleep_reg;
        end
    end

    // ==========================================
    // interrupt status, mask and detect control
    always @(posedge mclk) begin
        if (rst) begin
            irqStatus_reg <= {`SCTL_IRQ_W{1'b0}};
            irqMask_reg <= {`SCTL_IRQ_W{1'b0}};
            detCtrl_reg <= `SCTL_DET_RST;
            irq <= 1'b0;
        end else if (ce) begin
            // write one clears, a new event in the same cycle wins
            irqStatus_reg[`SCTL_IRQ_CAUGHT] <= caughtPulse |
                (irqStatus_reg[`SCTL_IRQ_CAUGHT] &
                ~(wrStat & wStrb_reg[0] & wData_reg[`SCTL_IRQ_CAUGHT]));
            irqStatus_reg[`SCTL_IRQ_ERR] <= errRise |
                (irqStatus_reg[`SCTL_IRQ_ERR] &
                ~(wrStat & wStrb_reg[0] & wData_reg[`SCTL_IRQ_ERR]));
            if (wrMask && wStrb_reg[0]) begin
                irqMask_reg <= wData_reg[`SCTL_IRQ_W-1:0];
            end
            if (wrDet && wStrb_reg[0]) begin
                detCtrl_reg <= wData_reg[4:0];
            end
            // level output from masked sticky bits
            irq <= |(irqStatus_reg & irqMask_reg);
        end
    end

    // ==========================================
    // axi4-lite write channels
    always @(posedge mclk) begin
        if (rst) begin
            awHeld_reg <= 1'b0;
            awAddr_reg <= {ADDR_W{1'b0}};
            wHeld_reg <= 1'b0;
            wData_reg <= 32'h0000_0000;
            wStrb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SCTL_RESP_OKAY;
        end else if (ce) begin
            // address and data taken independently, in either order
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_reg <= 1'b1;
                awAddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_reg <= 1'b1;
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end
            if (doWrite) begin
                // both present: commit and answer
                awHeld_reg <= 1'b0;
                wHeld_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wrSys | wrStat | wrMask | wrDet) ?
                    `SCTL_RESP_OKAY : `SCTL_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            // ready while nothing held and no answer pending
            s_axi_awready <= ~awHeld_reg & ~s_axi_bvalid & ~doWrite &
                ~(s_axi_awvalid & s_axi_awready);
            s_axi_wready <= ~wHeld_reg & ~s_axi_bvalid & ~doWrite &
                ~(s_axi_wvalid & s_axi_wready);
        end
    end

    // ==========================================
    // axi4-lite read channels
    always @(posedge mclk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SCTL_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                // take address, answer next edge
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `SCTL_RESP_OKAY;
                if (isAddr(s_axi_araddr, `SCTL_OFF_SYSTEM_CONTROL)) begin
                    s_axi_rdata <= sysWord;
                end else if (isAddr(s_axi_araddr, `SCTL_OFF_IRQSTAT)) begin
                    s_axi_rdata <= {30'h0000_0000, irqStatus_reg};
                end else if (isAddr(s_axi_araddr, `SCTL_OFF_IRQMASK)) begin
                    s_axi_rdata <= {30'h0000_0000, irqMask_reg};
                end else if (isAddr(s_axi_araddr, `SCTL_OFF_DETCTRL)) begin
                    s_axi_rdata <= {27'h000_0000, detCtrl_reg};
                end else begin
                    // unmapped: zero data, slave error
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `SCTL_RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ==========================================
    // current detector
    sctl_current_detect #(
        .LEN_W(LEN_W)
    ) uDetect (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .enable(detCtrl_reg[`SCTL_DET_EN_BIT]),
        .windowLen(detCtrl_reg[`SCTL_DET_LEN_F]),
        .sampleValid(currentSampleValid),
        .sampleAbove(currentAboveThreshold),
        .caughtPulse(caughtPulse),
        .belowNow(belowNow)
    );

    // ==========================================
    // clock enables, divider and sleep gating
    sctl_clock_gen uClocks (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .sleep(sleep_reg),
        .slowSelect(clockDivSel_reg),
        .internalClockAEn(internalClockAEn),
        .internalClockBEn(internalClockBEn),
        .meteringClockTick(meteringClockTick)
    );
endmodule // sctl_system_control

// File: testbench/sctl_system_control_monitor.sv
// concurrent checks on the ports of the system control register bank
`timescale 1ns/1ps
module sctl_system_control_monitor (
    input wire mclk,
    input wire rst,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [2:0] inputSelectA,
    input wire routeCurrent,
    input wire routeTemperature,
    input wire routeGround,
    input wire sleepMode,
    input wire internalClockAEn,
    input wire internalClockBEn,
    input wire meteringClockTick
);
    // ==========
    // one clock domain, reset disables all checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // ==========
    // analog routing and clock gating
    property p_route;
        $stable(inputSelectA) |-> {routeCurrent, routeTemperature, routeGround} ==
            {inputSelectA == 3'h0, inputSelectA == 3'h4, inputSelectA > 3'h4};
    endproperty
    a_route: assert property (p_route) else $error("route decode mismatch");
    property p_clk_gate;
        $stable(sleepMode) |-> internalClockAEn == !sleepMode && internalClockBEn == !sleepMode;
    endproperty
    a_clk_gate: assert property (p_clk_gate) else $error("clock enable vs sleep");
    property p_tick_sleep;
        sleepMode && $past(sleepMode) |-> !meteringClockTick;
    endproperty
    a_tick_sleep: assert property (p_tick_sleep) else $error("tick while asleep");
    property p_tick_gap;
        meteringClockTick |=> (!meteringClockTick) [*8];
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("metering ticks too close");

    // ==========
    // bus handshake timing
    property p_wr_lat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=>
            !s_axi_bvalid ##1 s_axi_bvalid;
    endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("write response late");
    property p_wr_done;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##[0:1] (s_axi_awready && s_axi_wready);
    endproperty
    a_wr_done: assert property (p_wr_done) else $error("write channel not released");
    property p_rd_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read data late");
    property p_rd_done;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##[0:1] s_axi_arready;
    endproperty
    a_rd_done: assert property (p_rd_done) else $error("read channel not released");
endmodule // sctl_system_control_monitor

bind sctl_system_control sctl_system_control_monitor u_mon (.mclk(mclk), .rst(rst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .inputSelectA(inputSelectA), .routeCurrent(routeCurrent),
    .routeTemperature(routeTemperature), .routeGround(routeGround), .sleepMode(sleepMode),
    .internalClockAEn(internalClockAEn), .internalClockBEn(internalClockBEn),
    .meteringClockTick(meteringClockTick));

// File: testbench/system_control_register_tb.sv
// self-checking bench for the system control register bank
`timescale 1ns/1ps
`include "sctl_regs.vh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module system_control_register_tb;
    // ==========
    // stimulus and observed signals
    reg mclk = 0, rst = 1, voltageSignIn = 0, currentSampleValid = 0, currentAboveThreshold = 0;
    reg [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    reg [31:0] s_axi_wdata = 0, rd, w;
    reg [3:0] s_axi_wstrb = 0;
    reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [2:0] inputSelectA;
    wire routeCurrent, routeTemperature, routeGround, sleepMode;
    wire internalClockAEn, internalClockBEn, meteringClockTick;
    integer errors = 0, checks = 0, seed = 13, i, g;
    reg [1:0] rsp;
    reg [8:0] lo;
    sctl_system_control u_dut (.mclk(mclk), .rst(rst), .ce(1'b1), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .voltageSignIn(voltageSignIn),
        .currentSampleValid(currentSampleValid), .currentAboveThreshold(currentAboveThreshold),
        .inputSelectA(inputSelectA), .routeCurrent(routeCurrent),
        .routeTemperature(routeTemperature), .routeGround(routeGround), .sleepMode(sleepMode),
        .internalClockAEn(internalClockAEn), .internalClockBEn(internalClockBEn),
        .meteringClockTick(meteringClockTick), .irq(irq));
    initial forever #12.5 mclk = ~mclk;
    // ==========
    // expectations: complement copy word and readback view
    function [31:0] good(input [8:0] l);
        good = {7'h0, ~l, 7'h0, l};
    endfunction
    function [31:0] expRd(input [31:0] v, input c, input s);
        expRd = {7'h0, v[24:21], v[24:16] !== ~v[8:0], v[19], c, s, v[16], 7'h0, v[8:0]};
    endfunction
    // ==========
    // axi4-lite write, both channels offered together
    task automatic wr(input [11:0] a, input [31:0] d, input [3:0] s, output [1:0] r);
        begin
            @(posedge mclk);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_wstrb <= s;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            do begin
                @(posedge mclk);
                if (s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wready) s_axi_wvalid <= 1'b0;
            end while (!s_axi_bvalid);
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
        end
    endtask
    // axi4-lite read, waits for the answer
    task automatic rdReg(input [11:0] a, output [31:0] d, output [1:0] r);
        begin
            @(posedge mclk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            do begin
                @(posedge mclk);
                if (s_axi_arready) s_axi_arvalid <= 1'b0;
            end while (!s_axi_rvalid);
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
        end
    endtask
    // one current sample strobe, then time for the flag to settle
    task automatic smp(input a);
        begin
            @(posedge mclk);
            currentSampleValid <= 1'b1;
            currentAboveThreshold <= a;
            @(posedge mclk);
            currentSampleValid <= 1'b0;
            repeat (3) @(posedge mclk);
        end
    endtask
    // cycles between two metering ticks, 200 if none
    task automatic tickGap(output integer n);
        begin
            for (n = 0; n < 200 && !meteringClockTick; n++) @(posedge mclk);
            @(posedge mclk);
            for (n = 1; n < 200 && !meteringClockTick; n++) @(posedge mclk);
        end
    endtask
    task conclude;
        begin
            $display("checks %0d errors %0d", checks, errors);
            if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    initial begin
        #1000000;
        errors++;
        conclude;
    end
    // ==========
    // main sequence
    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        rdReg(`SCTL_OFF_SYSTEM_CONTROL, rd, rsp);
        `CHK(rd, 32'h0010_0004)
        `CHK({routeCurrent, sleepMode, internalClockAEn, internalClockBEn}, 4'hB)
        $display("test reset done");
        for (i = 0; i < 8; i++) begin
            lo = $random(seed);
            lo[7:5] = i[2:0];
            lo[0] = 1'b0;
            w = good(lo);
            w[15:9] = $random(seed);
            if (i[0]) w[24:16] = $random(seed);
            wr(`SCTL_OFF_SYSTEM_CONTROL, w, 4'hF, rsp);
            rdReg(`SCTL_OFF_SYSTEM_CONTROL, rd, rsp);
            `CHK(rd, expRd(w, 1'b0, 1'b0))
            `CHK({routeCurrent, routeTemperature, routeGround}, {i == 0, i == 4, i > 4})
            `CHK(inputSelectA, i[2:0])
        end
        $display("test select and self-check done");
        for (i = 1; i >= 0; i--) begin
            voltageSignIn <= i[0];
            repeat (3) @(posedge mclk);
            rdReg(`SCTL_OFF_SYSTEM_CONTROL, rd, rsp);
            `CHK(rd[17], i[0])
        end
        for (i = 0; i < 2; i++) begin
            wr(`SCTL_OFF_SYSTEM_CONTROL, good({4'h0, 3'h1, i[0], 1'b0}), 4'hF, rsp);
            tickGap(g);
            tickGap(g);
            `CHK(g, i ? 48 : 12)
        end
        wr(`SCTL_OFF_SYSTEM_CONTROL, good(9'h005), 4'hF, rsp);
        repeat (3) @(posedge mclk);
        `CHK({sleepMode, internalClockAEn, internalClockBEn}, 3'h4)
        tickGap(g);
        `CHK(g, 200)
        wr(`SCTL_OFF_SYSTEM_CONTROL, good(9'h004), 4'hF, rsp);
        wr(12'h1F0, 32'h0, 4'hF, rsp);
        `CHK(rsp, `SCTL_RESP_SLVERR)
        rdReg(12'h184, rd, rsp);
        `CHK({rd, rsp}, {32'h0, `SCTL_RESP_SLVERR})
        $display("test clocks and decode done");
        wr(`SCTL_OFF_IRQSTAT, 32'h3, 4'hF, rsp);
        wr(`SCTL_OFF_DETCTRL, 32'h7, 4'hF, rsp);
        for (i = 0; i < 3; i++) smp(1'b1);
        rdReg(`SCTL_OFF_SYSTEM_CONTROL, rd, rsp);
        `CHK(rd[18], 1'b0)
        smp(1'b1);
        rdReg(`SCTL_OFF_SYSTEM_CONTROL, rd, rsp);
        `CHK({rd[18], irq}, 2'h2)
        wr(`SCTL_OFF_IRQMASK, 32'h1, 4'hF, rsp);
        repeat (2) @(posedge mclk);
        `CHK(irq, 1'b1)
        for (i = 1; i >= 0; i--) begin
            if (i == 0) smp(1'b0);
            wr(`SCTL_OFF_SYSTEM_CONTROL, good(9'h004), 4'h4, rsp);
            rdReg(`SCTL_OFF_SYSTEM_CONTROL, rd, rsp);
            `CHK(rd, expRd(good(9'h004), i[0], 1'b0))
        end
        wr(`SCTL_OFF_IRQSTAT, 32'h1, 4'hF, rsp);
        repeat (2) @(posedge mclk);
        `CHK(irq, 1'b0)
        $display("test detection and interrupt done");
        conclude;
    end
endmodule // system_control_register_tb
